// ===== rtl/host_read_defines.svh
// constants for the 16-bit host read port: timing, address map and reset levels
// Notes on behaviour
// - cycle runs while select and strobe both low
// - register values captured when the read begins
// - address selects registers, data or status FIFOs
// - single reads separated by a high gap
// - strobes held low; whole cycle at least 165 ns
// - bursts up to sixteen words, one per address
// - high gap required between two bursts
// - FIFO select forces reads of receive data
// - direct mode keeps A2..A1, ignores A7..A3
// - direct mode bursts have no word limit
// - FIFO select timed like the address lines
// - direct bursts keep a released strobe high
// - every access moves one 16-bit word
// - wait one cycle before reading fill info
`ifndef HOST_READ_DEFINES_SVH
`define HOST_READ_DEFINES_SVH

// ----------------------------------------
// clock and link timing
// ----------------------------------------
`define CLK_NS        50
`define TCYCLE_NS     165
`define TCSL_NS       32
`define TCSH_NS       13
`define TCYCLE_CYC    ((`TCYCLE_NS + `CLK_NS - 1) / `CLK_NS)
`define TCSL_CYC      ((`TCSL_NS + `CLK_NS - 1) / `CLK_NS)
`define TCSH_CYC      ((`TCSH_NS + `CLK_NS - 1) / `CLK_NS)
// edges from a host pin change to a filtered answer back at the host
`define RESPONSE_CYC  11
// the three-flop filter needs a level to stand two samples
`define FILTER_CYC    2
`define WORD_CYC      ((`TCYCLE_CYC > `RESPONSE_CYC) ? `TCYCLE_CYC : `RESPONSE_CYC)
`define GAP_CYC       ((`TCSH_CYC > `FILTER_CYC) ? `TCSH_CYC : `FILTER_CYC)
`define FENCE_CYC     `TCYCLE_CYC
`define BURST_MAX     16

// ----------------------------------------
// widths, address map and idle levels
// ----------------------------------------
`define DATA_W          16
`define FIFO_DEPTH      32
`define RX_DATA_REGION  5'h00
`define RX_STAT_REGION  5'h08
`define TX_STAT_REGION  5'h09
`define RX_FILL_INFO_WORD 7'h3e
`define FLOAT_LEVEL     16'hffff
`define PIN_IDLE        10'h300

`endif

// ===== rtl/host_read_pkg.sv
// types shared by both ends of the host read port
package host_read_pkg;
   typedef enum logic [1:0] {SRC_CSR, SRC_RX_DATA, SRC_RX_STATUS, SRC_TX_STATUS} source_t;
   typedef enum logic [1:0] {DEV_IDLE, DEV_CAPTURE, DEV_HOLD} dev_state_t;
   typedef enum logic [1:0] {HOST_IDLE, HOST_WORD, HOST_GAP} host_state_t;
endpackage

// ===== rtl/host_read_if.sv
// pin bundle between the host and the device read port
`timescale 1ns/1ps
`include "host_read_defines.svh"
interface host_read_if;
   logic                chip_select_low;
   logic                read_strobe_low;
   logic                fifo_sel;
   logic [7:1]          addr;
   logic [`DATA_W-1:0]  data_out;
   logic                data_oe;
   wire  [`DATA_W-1:0]  data_bus;

   // an undriven bus reads as the pulled-up level
   assign data_bus = data_oe ? data_out : `FLOAT_LEVEL;

   modport device (
      input  chip_select_low,
      input  read_strobe_low,
      input  fifo_sel,
      input  addr,
      output data_out,
      output data_oe
   );
   modport host (
      output chip_select_low,
      output read_strobe_low,
      output fifo_sel,
      output addr,
      input  data_bus
   );
endinterface // host_read_if

// ===== rtl/read_port_device.sv
// device end of the host read port and its receive data FIFO
`timescale 1ns/1ps
`include "host_read_defines.svh"

// ----------------------------------------
// word FIFO
// ----------------------------------------
module word_fifo #(
   parameter int WIDTH = `DATA_W,
   parameter int DEPTH = `FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // fill side
   input  wire logic                   in_valid,
   output logic                        in_ready,
   input  wire logic [WIDTH-1:0]       in_data,
   // drain side
   output logic                        out_valid,
   input  wire logic                   out_ready,
   output logic [WIDTH-1:0]            out_data,
   // occupancy
   output logic [$clog2(DEPTH):0]      level
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("word_fifo depth must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   wire  logic       push;
   wire  logic       pop;

   // pointers carry a wrap bit so full and empty differ
   assign out_valid = (wr_ptr != rd_ptr);
   assign in_ready  = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem[rd_ptr[AW-1:0]];
   assign level     = wr_ptr - rd_ptr;

   // storage has no reset; only entries behind the pointers are read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   // pointer update
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule // word_fifo

// ----------------------------------------
// device read port
// ----------------------------------------
module read_port_device #(
   parameter int DEPTH = `FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // host pins
   host_read_if.device                 link,
   // receive data fill side
   input  wire logic                   rx_valid,
   output logic                        rx_ready,
   input  wire logic [`DATA_W-1:0]     rx_data,
   // receive status stream
   input  wire logic                   rxs_valid,
   input  wire logic [`DATA_W-1:0]     rxs_data,
   output logic                        rxs_pop,
   // transmit status stream
   input  wire logic                   txs_valid,
   input  wire logic [`DATA_W-1:0]     txs_data,
   output logic                        txs_pop,
   // register snapshot source
   output logic [6:0]                  csr_index,
   input  wire logic [`DATA_W-1:0]     csr_data,
   // diagnostics
   output logic                        burst_overrun
);
   localparam int PW = 10;

   logic [PW-1:0]              s1;
   logic [PW-1:0]              s2;
   logic [PW-1:0]              s3;
   logic [PW-1:0]              filt;
   host_read_pkg::dev_state_t  state;
   host_read_pkg::source_t     cur_src;
   logic [6:0]                 word_addr;
   logic [`DATA_W-1:0]         data_q;
   logic                       hit;
   logic                       fsel_q;
   logic [4:0]                 words;
   logic                       fifo_valid;
   logic [`DATA_W-1:0]         fifo_data;
   logic [$clog2(DEPTH):0]     fifo_level;

   // ----------------------------------------
   // pin filter
   // ----------------------------------------
   wire logic [PW-1:0] pins  = {link.chip_select_low, link.read_strobe_low, link.fifo_sel,
                                link.addr};
   wire logic [PW-1:0] agree = ~(s2 ^ s3);
   wire logic [PW-1:0] next_filt = (s2 & agree) | (filt & ~agree);

   // s1 feeds only s2; a level counts once s2 and s3 agree
   always_ff @(posedge clk) begin
      if (rst) begin
         s1   <= `PIN_IDLE;
         s2   <= `PIN_IDLE;
         s3   <= `PIN_IDLE;
         filt <= `PIN_IDLE;
      end else begin
         s1   <= pins;
         s2   <= s1;
         s3   <= s2;
         filt <= next_filt;
      end
   end

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire logic       active   = ~filt[9] & ~filt[8];
   wire logic       fsel     = filt[7];
   wire logic [6:0] pin_word = filt[6:0];
   // direct mode keeps the low word bits and forces the data region
   wire logic [6:0] eff_word = fsel ? {`RX_DATA_REGION, pin_word[1:0]} : pin_word;
   wire logic [4:0] region   = eff_word[6:2];
   wire host_read_pkg::source_t next_src =
      (region == `RX_DATA_REGION) ? host_read_pkg::SRC_RX_DATA :
      (region == `RX_STAT_REGION) ? host_read_pkg::SRC_RX_STATUS :
      (region == `TX_STAT_REGION) ? host_read_pkg::SRC_TX_STATUS :
                                    host_read_pkg::SRC_CSR;
   // in a burst each new address is a new word
   wire logic       word_changed = (eff_word != word_addr) || (fsel != fsel_q);

   // fill info reports our own FIFO level
   wire logic [`DATA_W-1:0] fill_word = `DATA_W'(fifo_level);
   wire logic [`DATA_W-1:0] csr_word  =
      (word_addr == `RX_FILL_INFO_WORD) ? fill_word : csr_data;
   // empty FIFOs read as zero and are not popped
   wire logic [`DATA_W-1:0] read_word =
      (cur_src == host_read_pkg::SRC_RX_DATA)   ? (fifo_valid ? fifo_data : '0) :
      (cur_src == host_read_pkg::SRC_RX_STATUS) ? (rxs_valid ? rxs_data : '0) :
      (cur_src == host_read_pkg::SRC_TX_STATUS) ? (txs_valid ? txs_data : '0) :
                                                  csr_word;
   wire logic src_ready =
      (cur_src == host_read_pkg::SRC_RX_DATA)   ? fifo_valid :
      (cur_src == host_read_pkg::SRC_RX_STATUS) ? rxs_valid :
      (cur_src == host_read_pkg::SRC_TX_STATUS) ? txs_valid : 1'b0;

   // a word completes when the cycle ends or the address moves on
   wire logic word_done = (state == host_read_pkg::DEV_HOLD) && (!active || word_changed);
   wire logic pop_fire  = word_done & hit;
   wire logic rx_pop    = pop_fire && (cur_src == host_read_pkg::SRC_RX_DATA);
   wire logic start_word =
      ((state == host_read_pkg::DEV_IDLE) && active) ||
      ((state == host_read_pkg::DEV_HOLD) && active && word_changed);

   assign rxs_pop   = pop_fire && (cur_src == host_read_pkg::SRC_RX_STATUS);
   assign txs_pop   = pop_fire && (cur_src == host_read_pkg::SRC_TX_STATUS);
   assign csr_index = word_addr;
   // drive only while a word is being served
   assign link.data_oe  = (state != host_read_pkg::DEV_IDLE);
   assign link.data_out = data_q;

   // ----------------------------------------
   // cycle state machine
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= host_read_pkg::DEV_IDLE;
      end else begin
         unique case (state)
            host_read_pkg::DEV_IDLE: begin
               if (active) begin
                  state <= host_read_pkg::DEV_CAPTURE;
               end
            end
            host_read_pkg::DEV_CAPTURE: begin
               state <= host_read_pkg::DEV_HOLD;
            end
            host_read_pkg::DEV_HOLD: begin
               if (!active) begin
                  state <= host_read_pkg::DEV_IDLE;
               end else if (word_changed) begin
                  state <= host_read_pkg::DEV_CAPTURE;
               end
            end
            default: begin
               state <= host_read_pkg::DEV_IDLE;
            end
         endcase
      end
   end

   // address and source are frozen for the whole word
   always_ff @(posedge clk) begin
      if (rst) begin
         word_addr <= 7'h00;
         fsel_q    <= 1'b0;
         cur_src   <= host_read_pkg::SRC_CSR;
      end else if (start_word) begin
         word_addr <= eff_word;
         fsel_q    <= fsel;
         cur_src   <= next_src;
      end
   end

   // snapshot taken once per word so the value cannot move under the host
   always_ff @(posedge clk) begin
      if (rst) begin
         data_q <= 16'h0000;
         hit    <= 1'b0;
      end else if (state == host_read_pkg::DEV_CAPTURE) begin
         data_q <= read_word;
         hit    <= src_ready;
      end
   end

   // words of the current burst; register bursts beyond the limit are flagged
   always_ff @(posedge clk) begin
      if (rst) begin
         words         <= 5'h00;
         burst_overrun <= 1'b0;
      end else if ((state == host_read_pkg::DEV_IDLE) && active) begin
         words         <= 5'h00;
         burst_overrun <= 1'b0;
      end else if (state == host_read_pkg::DEV_CAPTURE) begin
         words <= (words == 5'h1f) ? words : words + 5'h01;
         if (!fsel_q && (words == 5'(`BURST_MAX))) begin
            burst_overrun <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // receive data buffer
   // ----------------------------------------
   word_fifo #(
      .WIDTH (`DATA_W),
      .DEPTH (DEPTH)
   ) u_rx_fifo (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (rx_valid),
      .in_ready  (rx_ready),
      .in_data   (rx_data),
      .out_valid (fifo_valid),
      .out_ready (rx_pop),
      .out_data  (fifo_data),
      .level     (fifo_level)
   );
endmodule // read_port_device

// ===== rtl/read_port_host.sv
// host end of the read port: turns word requests into strobe cycles
`timescale 1ns/1ps
`include "host_read_defines.svh"
module read_port_host (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // device pins
   host_read_if.host                   link,
   // request
   input  wire logic                   req_valid,
   output logic                        req_ready,
   input  wire logic                   req_fifo_sel,
   input  wire logic [6:0]             req_addr,
   input  wire logic [7:0]             req_words,
   // answer
   output logic                        rsp_valid,
   output logic [`DATA_W-1:0]          rsp_data,
   output logic                        rsp_last
);
   host_read_pkg::host_state_t state;
   logic                       cs_pin;
   logic                       rd_pin;
   logic                       fsel;
   logic [6:0]                 addr;
   logic [7:0]                 remaining;
   logic [4:0]                 burst_cnt;
   logic [7:0]                 cnt;
   logic [7:0]                 gap_len;
   logic                       resume;
   logic                       last_fifo;
   logic [`DATA_W-1:0]         d1;
   logic [`DATA_W-1:0]         d2;
   logic [`DATA_W-1:0]         d3;
   logic [`DATA_W-1:0]         dfilt;

   assign link.chip_select_low = cs_pin;
   assign link.read_strobe_low = rd_pin;
   assign link.fifo_sel        = fsel;
   assign link.addr            = addr;
   assign req_ready            = (state == host_read_pkg::HOST_IDLE);

   // ----------------------------------------
   // data bus filter
   // ----------------------------------------
   wire logic [`DATA_W-1:0] agree = ~(d2 ^ d3);
   always_ff @(posedge clk) begin
      if (rst) begin
         d1    <= `FLOAT_LEVEL;
         d2    <= `FLOAT_LEVEL;
         d3    <= `FLOAT_LEVEL;
         dfilt <= `FLOAT_LEVEL;
      end else begin
         d1    <= link.data_bus;
         d2    <= d1;
         d3    <= d2;
         dfilt <= (d2 & agree) | (dfilt & ~agree);
      end
   end

   // ----------------------------------------
   // decisions
   // ----------------------------------------
   wire logic take      = req_valid & req_ready;
   // fill info read straight after a receive data or receive status FIFO read waits one full cycle
   wire logic fence     = last_fifo && !req_fifo_sel && (req_addr == `RX_FILL_INFO_WORD);
   wire logic word_end  = (state == host_read_pkg::HOST_WORD) &&
                          (cnt == 8'(`WORD_CYC - 1));
   wire logic last_word = (remaining == 8'h00);
   // register bursts are split at the limit; direct bursts run on
   wire logic split     = !fsel && (burst_cnt == 5'(`BURST_MAX - 1));
   wire logic gap_end   = (state == host_read_pkg::HOST_GAP) && (cnt >= gap_len - 8'h01);
   wire logic fifo_word = fsel || (addr[6:2] == `RX_DATA_REGION) ||
                          (addr[6:2] == `RX_STAT_REGION);

   // ----------------------------------------
   // strobe sequencer
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= host_read_pkg::HOST_IDLE;
         cs_pin <= 1'b1;
         rd_pin <= 1'b1;
         cnt    <= 8'h00;
         gap_len <= 8'h00;
         resume <= 1'b0;
      end else begin
         unique case (state)
            host_read_pkg::HOST_IDLE: begin
               cnt <= 8'h00;
               if (take && fence) begin
                  state   <= host_read_pkg::HOST_GAP;
                  gap_len <= 8'(`FENCE_CYC);
                  resume  <= 1'b1;
               end else if (take) begin
                  state  <= host_read_pkg::HOST_WORD;
                  cs_pin <= 1'b0;
                  rd_pin <= 1'b0;
               end
            end
            host_read_pkg::HOST_WORD: begin
               cnt <= word_end ? 8'h00 : cnt + 8'h01;
               if (word_end && (last_word || split)) begin
                  state   <= host_read_pkg::HOST_GAP;
                  cs_pin  <= 1'b1;
                  rd_pin  <= 1'b1;
                  gap_len <= 8'(`GAP_CYC);
                  resume  <= !last_word;
               end
            end
            host_read_pkg::HOST_GAP: begin
               cnt <= gap_end ? 8'h00 : cnt + 8'h01;
               if (gap_end && resume) begin
                  state  <= host_read_pkg::HOST_WORD;
                  cs_pin <= 1'b0;
                  rd_pin <= 1'b0;
               end else if (gap_end) begin
                  state <= host_read_pkg::HOST_IDLE;
               end
            end
            default: begin
               state <= host_read_pkg::HOST_IDLE;
            end
         endcase
      end
   end

   // address walks one word per sample; the count tracks the burst
   always_ff @(posedge clk) begin
      if (rst) begin
         fsel      <= 1'b0;
         addr      <= 7'h00;
         remaining <= 8'h00;
         burst_cnt <= 5'h00;
         last_fifo <= 1'b0;
      end else if (take) begin
         fsel      <= req_fifo_sel;
         addr      <= req_addr;
         remaining <= req_words;
         burst_cnt <= 5'h00;
         last_fifo <= 1'b0;
      end else if (word_end) begin
         last_fifo <= fifo_word;
         if (!last_word) begin
            addr      <= addr + 7'h01;
            remaining <= remaining - 8'h01;
            burst_cnt <= split ? 5'h00 : burst_cnt + 5'h01;
         end
      end
   end

   // answer stands one cycle per word
   always_ff @(posedge clk) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp_data  <= 16'h0000;
         rsp_last  <= 1'b0;
      end else begin
         rsp_valid <= word_end;
         rsp_last  <= word_end && last_word;
         if (word_end) begin
            rsp_data <= dfilt;
         end
      end
   end
endmodule // read_port_host

// ===== verification/host_read_monitor.sv
// concurrent checks on the pins joining the host and device read ends
`timescale 1ns/1ps
`include "host_read_defines.svh"
module host_read_monitor (
   // clock and reset
   input wire logic               clk,
   input wire logic               rst,
   // host pins
   input wire logic               chip_select_low,
   input wire logic               read_strobe_low,
   input wire logic               fifo_sel,
   input wire logic [7:1]         addr,
   // device pins
   input wire logic [`DATA_W-1:0] data_out,
   input wire logic               data_oe,
   input wire logic [`DATA_W-1:0] data_bus
);
   // ----------------------------------------
   // helper logic
   // ----------------------------------------
   logic       idle;
   logic [3:0] steady;
   // either strobe high means no cycle runs
   assign idle = chip_select_low | read_strobe_low;
   // counts cycles of one unchanged access; data checks wait out the pin filters
   always_ff @(posedge clk) begin
      if (rst || idle || $changed(addr) || $changed(fifo_sel)) begin
         steady <= 4'h0;
      end else if (steady != 4'hf) begin
         steady <= steady + 4'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   property p_oe_start;
      $rose(data_oe) |-> $past(!idle, 2) && $past(!idle, 4);
   endproperty
   a_oe_start: assert property (p_oe_start)
      else $error("data bus driven without a running cycle");
   property p_oe_end;
      $rose(idle) |-> ##[1:7] !data_oe;
   endproperty
   a_oe_end: assert property (p_oe_end)
      else $error("data bus still driven after the cycle ended");
   property p_oe_idle;
      idle [*8] |-> !data_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("data bus driven while idle");
   property p_hold;
      (steady >= 4'h8 && $past(data_oe)) |-> $stable(data_out);
   endproperty
   a_hold: assert property (p_hold)
      else $error("read data changed within one access");
   property p_gap;
      $rose(idle) |-> idle [*2];
   endproperty
   a_gap: assert property (p_gap)
      else $error("strobe high gap too short");
   property p_low;
      $fell(idle) |-> !idle [*8];
   endproperty
   a_low: assert property (p_low)
      else $error("strobes released too early");
   property p_acyc;
      (!idle && $past(!idle) && $changed(addr)) |-> ##1 $stable(addr) [*8];
   endproperty
   a_acyc: assert property (p_acyc)
      else $error("burst address changed too fast");
   property p_fsel;
      (!idle && $past(!idle)) |-> $stable(fifo_sel);
   endproperty
   a_fsel: assert property (p_fsel)
      else $error("fifo select moved during an access");
   property p_float;
      !data_oe |-> (data_bus == `FLOAT_LEVEL);
   endproperty
   a_float: assert property (p_float)
      else $error("data bus not released while the device is off it");
endmodule // host_read_monitor

// ===== verification/tb.sv
// self-checking bench joining the host and device ends of the read port
`timescale 1ns/1ps
`include "host_read_defines.svh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
   $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module tb;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   logic               rx_valid = 1'b0;
   logic [`DATA_W-1:0] rx_data = 16'h0000;
   logic               req_valid = 1'b0;
   logic               req_fifo_sel = 1'b0;
   logic [6:0]         req_addr = 7'h00;
   logic [7:0]         req_words = 8'h00;
   logic               csr_flip = 1'b0;
   logic [`DATA_W-1:0] rxs_cnt = 16'h0000;
   logic [`DATA_W-1:0] txs_cnt = 16'h0000;
   logic               rx_ready, rxs_pop, txs_pop, req_ready, rsp_valid, rsp_last, burst_overrun;
   logic [6:0]         csr_index;
   logic [`DATA_W-1:0] csr_data, rsp_data;
   logic [`DATA_W-1:0] got[$];
   int                 mismatches = 0;
   int                 tests_run = 0;
   int                 pushed;
   // register source flips on demand so a late snapshot would show
   assign csr_data = {csr_flip ? 9'h1aa : 9'h055, csr_index};
   always #25 clk = ~clk;
   // status streams step forward once per pop
   always @(posedge clk) begin
      if (rxs_pop === 1'b1) rxs_cnt <= rxs_cnt + 16'h0001;
      if (txs_pop === 1'b1) txs_cnt <= txs_cnt + 16'h0001;
   end
   host_read_if link ();
   read_port_device #(.DEPTH(32)) read_port_device_inst (
      .clk(clk), .rst(rst), .link(link),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
      .rxs_valid(1'b1), .rxs_data(16'h5000 + rxs_cnt), .rxs_pop(rxs_pop),
      .txs_valid(1'b1), .txs_data(16'h6000 + txs_cnt), .txs_pop(txs_pop),
      .csr_index(csr_index), .csr_data(csr_data), .burst_overrun(burst_overrun));
   read_port_host read_port_host_inst (
      .clk(clk), .rst(rst), .link(link),
      .req_valid(req_valid), .req_ready(req_ready), .req_fifo_sel(req_fifo_sel),
      .req_addr(req_addr), .req_words(req_words),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last));
   host_read_monitor host_read_monitor_inst (
      .clk(clk), .rst(rst), .chip_select_low(link.chip_select_low),
      .read_strobe_low(link.read_strobe_low), .fifo_sel(link.fifo_sel), .addr(link.addr),
      .data_out(link.data_out), .data_oe(link.data_oe), .data_bus(link.data_bus));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   // one request of wm1+1 words; answers gathered until the last word
   task automatic rd(input logic fs, input logic [6:0] a, input logic [7:0] wm1);
      int n;
      got.delete();
      @(posedge clk);
      req_valid <= 1'b1;
      req_fifo_sel <= fs;
      req_addr <= a;
      req_words <= wm1;
      @(posedge clk);
      while (req_ready !== 1'b1) @(posedge clk);
      req_valid <= 1'b0;
      for (n = 0; n < 3000; n++) begin
         @(posedge clk);
         if (rsp_valid === 1'b1) got.push_back(rsp_data);
         if (rsp_valid === 1'b1 && rsp_last === 1'b1) break;
      end
   endtask
   // answers must count up by one from first
   task automatic chk_seq(input string nm, input logic [15:0] first, input int cnt);
      `CHK({nm, " count"}, cnt, got.size())
      foreach (got[i]) `CHK(nm, first + 16'(i), got[i])
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ----------------------------------------
   // sequence
   // ----------------------------------------
   // whole run is under a thousand cycles; the limit leaves wide margin
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      results();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      // source flips after capture, before the answer reaches the host
      fork
         rd(1'b0, 7'h45, 8'h00);
         begin repeat (9) @(posedge clk); csr_flip <= 1'b1; end
      join
      chk_seq("csr snapshot", 16'h2ac5, 1);
      csr_flip <= 1'b0;
      // fill until the buffer refuses
      // first word must already stand with valid, or a stale zero is pushed
      rx_valid <= 1'b1;
      rx_data <= 16'h1000;
      pushed = 0;
      repeat (40) begin
         @(posedge clk);
         if (rx_ready === 1'b1) begin
            pushed++;
            rx_data <= 16'h1000 + 16'(pushed);
         end
      end
      rx_valid <= 1'b0;
      `CHK("fill count", 32, pushed)
      `CHK("full refuses", 1'b0, rx_ready)
      rd(1'b0, 7'h3e, 8'h00); chk_seq("fill level", 16'h0020, 1);
      rd(1'b0, 7'h00, 8'h03); chk_seq("data burst", 16'h1000, 4);
      rd(1'b1, 7'h7c, 8'h13); chk_seq("direct burst", 16'h1004, 20);
      `CHK("direct overrun", 1'b0, burst_overrun)
      rd(1'b1, 7'h45, 8'h00); chk_seq("direct single", 16'h1018, 1);
      rd(1'b1, 7'h01, 8'h06); chk_seq("drain", 16'h1019, 7);
      rd(1'b0, 7'h3e, 8'h00); chk_seq("empty level", 16'h0000, 1);
      rd(1'b1, 7'h00, 8'h00); chk_seq("empty read", 16'h0000, 1);
      rd(1'b0, 7'h20, 8'h00); chk_seq("rx status", 16'h5000, 1);
      rd(1'b0, 7'h24, 8'h00); chk_seq("tx status", 16'h6000, 1);
      rd(1'b0, 7'h21, 8'h01); chk_seq("status burst", 16'h5001, 2);
      rd(1'b0, 7'h40, 8'h10); chk_seq("csr burst", 16'h2ac0, 17);
      `CHK("split overrun", 1'b0, burst_overrun)
      results();
   end
endmodule // tb
